// *** rtl/sacs_sequencer.sv ***
// conversion sequencer for a 12-bit SAR converter that auto-zeros in single-ended mode
`default_nettype none
module sacs_sequencer #(
  parameter int SETTLE_CYC = sacs_pkg::SACS_SETTLE_CYC,
  parameter int TRIAL_CYC = sacs_pkg::SACS_TRIAL_CYC
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic single_ended_select_in,
  input wire logic [sacs_pkg::SACS_CH_W-1:0] chan_in,
  input wire logic comp_positive_in,
  input wire logic vern_wr_in,
  input wire logic [sacs_pkg::SACS_VERN_W-1:0] vern_data_in,
  output logic [sacs_pkg::SACS_CHANS-1:0] mux_en_out,
  output logic auto_zero_out,
  output logic sh_track_out,
  output logic preamp_to_comp_out,
  output logic [sacs_pkg::SACS_BITS-1:0] dac_code_out,
  output logic [sacs_pkg::SACS_BITS-1:0] result_out,
  output logic [sacs_pkg::SACS_VERN_W-1:0] vern_code_out,
  output logic busy_out,
  output logic done_out
);
  import sacs_pkg::*;
  sacs_state_e state_reg;
  logic [7:0] cnt_reg;
  logic [3:0] bit_reg;
  logic [11:0] sar_reg;
  logic cmp_s1_reg;
  logic cmp_s2_reg;
  logic se_reg;
  logic [3:0] chan_reg;
  logic hold;
  logic [11:0] sar_next;
  sacs_if sw ();

  // start accepted only while sampling
  function automatic logic start_taken(input sacs_state_e st,
                                       input logic req);
    start_taken = (st == SACS_SAMPLE) && req;
  endfunction

  // last cycle of a bit trial, comparator decision is due
  function automatic logic trial_end(input sacs_state_e st,
                                     input logic [7:0] cnt);
    trial_end = (st == SACS_TRIAL) && (cnt == 8'h00);
  endfunction

  // comparator arrives from analog side, two-stage synchroniser
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      cmp_s1_reg <= comp_positive_in;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end

  // phase sequencing
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= SACS_SAMPLE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
    end else begin
      case (state_reg)
        SACS_SAMPLE: begin
          if (start_in) begin
            state_reg <= SACS_FREEZE;
            cnt_reg <= 8'(SETTLE_CYC - 1);
            bit_reg <= 4'(SACS_BITS - 1);
          end
        end
        SACS_FREEZE: begin
          if (cnt_reg == 8'h00) begin
            state_reg <= SACS_TRIAL;
            cnt_reg <= 8'(TRIAL_CYC + 1);
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        SACS_TRIAL: begin
          if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else if (bit_reg == 4'h0) begin
            state_reg <= SACS_XFER;
          end else begin
            bit_reg <= bit_reg - 4'h1;
            cnt_reg <= 8'(TRIAL_CYC + 1);
          end
        end
        SACS_XFER: state_reg <= SACS_SAMPLE;
        default: state_reg <= SACS_SAMPLE;
      endcase
    end
  end

  // capture mode and channel at start so hold sees stable values
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      se_reg <= 1'b1;
      chan_reg <= 4'h0;
    end else if (state_reg == SACS_SAMPLE) begin
      se_reg <= single_ended_select_in;
      chan_reg <= chan_in;
    end
  end

  // next SAR value: preload at start, decide and advance per trial
  always_comb begin
    sar_next = sar_reg;
    if (start_taken(state_reg, start_in)) begin
      sar_next = SACS_SAR_PRELOAD;
    end else if (trial_end(state_reg, cnt_reg)) begin
      // decision for current bit, then try the next lower one
      if (cmp_s2_reg) begin
        sar_next[bit_reg] = 1'b0;
      end
      if (bit_reg != 4'h0) begin
        sar_next[bit_reg - 4'h1] = 1'b1;
      end
    end
  end

  // successive-approximation register
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sar_reg <= SACS_SAR_PRELOAD;
    end else begin
      sar_reg <= sar_next;
    end
  end

  // result buffer, offset binary as produced by the SAR
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_out <= SACS_RESULT_RESET;
    end else if (state_reg == SACS_XFER) begin
      result_out <= sar_reg;
    end
  end

  // vernier offset code, write-only; scale of 2.5 LSB is analog
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vern_code_out <= SACS_VERN_RESET;
    end else if (vern_wr_in) begin
      vern_code_out <= vern_data_in;
    end
  end

  // switch decode shared through the interface
  assign hold = (state_reg != SACS_SAMPLE) && (state_reg != SACS_XFER);
  assign sw.hold = hold;
  assign sw.single_ended_select = se_reg;
  assign sw.chan = chan_reg;
  sacs_mux_decode u_dec (
    .sw(sw)
  );

  // multiplexer and auto-zero switches, registered
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mux_en_out <= 16'h0000;
      auto_zero_out <= 1'b0;
    end else begin
      mux_en_out <= sw.mux_en;
      auto_zero_out <= sw.auto_zero;
    end
  end

  // feedback path: track in sample, preamp to comparator in hold
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_track_out <= 1'b1;
      preamp_to_comp_out <= 1'b0;
    end else begin
      sh_track_out <= !hold;
      preamp_to_comp_out <= hold;
    end
  end

  // feedback DAC loads in step with the SAR, leaving two sync
  // stages and TRIAL_CYC settle cycles inside each trial interval
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dac_code_out <= SACS_SAR_PRELOAD;
    end else begin
      dac_code_out <= sar_next;
    end
  end

  // conversion status
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      busy_out <= hold;
      done_out <= (state_reg == SACS_XFER);
    end
  end
endmodule
`default_nettype wire

// *** rtl/sacs_pkg.sv ***
// constants and types shared by the conversion sequencer
`default_nettype none
package sacs_pkg;
  localparam int SACS_BITS = 12;
  localparam int SACS_CHANS = 16;
  localparam int SACS_CH_W = 4;
  localparam int SACS_VERN_W = 8;
  // successive-approximation preload, only the top bit set
  localparam logic [11:0] SACS_SAR_PRELOAD = 12'h800;
  localparam logic [11:0] SACS_RESULT_RESET = 12'h000;
  // vernier midscale, zero offset in offset binary
  localparam logic [7:0] SACS_VERN_RESET = 8'h80;
  // settle and bit trial times
  localparam int SACS_CLK_MHZ = 125;
  localparam int SACS_SETTLE_NS = 80;
  localparam int SACS_TRIAL_NS = 40;
  localparam int SACS_SETTLE_CYC =
    (SACS_SETTLE_NS * SACS_CLK_MHZ + 999) / 1000;
  localparam int SACS_TRIAL_CYC =
    (SACS_TRIAL_NS * SACS_CLK_MHZ + 999) / 1000;
  typedef enum logic [3:0] {
    SACS_SAMPLE = 4'b0001,
    SACS_FREEZE = 4'b0010,
    SACS_TRIAL = 4'b0100,
    SACS_XFER = 4'b1000
  } sacs_state_e;
endpackage
`default_nettype wire

// *** rtl/sacs_if.sv ***
// front-end switch controls shared between sequencer and its decoder
`default_nettype none
interface sacs_if;
  logic hold;
  logic single_ended_select;
  logic [3:0] chan;
  logic [15:0] mux_en;
  logic auto_zero;
  modport ctrl (output hold, single_ended_select, chan,
    input mux_en, auto_zero);
  modport dec (input hold, single_ended_select, chan,
    output mux_en, auto_zero);
endinterface
`default_nettype wire

// *** rtl/sacs_mux_decode.sv ***
// decoder from phase and channel to multiplexer and auto-zero switches
`default_nettype none
module sacs_mux_decode (
  sacs_if.dec sw
);
  import sacs_pkg::*;
  // negative leg of a pair is the odd partner of the channel
  function automatic logic [15:0] one_hot(input logic [3:0] c);
    one_hot = 16'h0001 << c;
  endfunction
  // switch selection per phase
  always_comb begin
    sw.mux_en = 16'h0000;
    sw.auto_zero = 1'b0;
    if (!sw.hold) begin
      sw.mux_en = one_hot(sw.chan);
    end else if (sw.single_ended_select) begin
      sw.auto_zero = 1'b1;
    end else begin
      sw.mux_en = one_hot(sw.chan | 4'h1);
    end
  end
endmodule
`default_nettype wire

// *** test/sacs_afe_model.sv ***
// behavioural front end: comparator against a held input level
`default_nettype none
module sacs_afe_model (
  input wire logic [11:0] dac_in,
  input wire logic [11:0] level_in,
  output logic comp_positive_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // node positive while feedback code is above the level
  assign comp_positive_out = dac_in > level_in;
endmodule
`default_nettype wire

// *** test/sacs_sequencer_assertions.sv ***
// concurrent checks on the conversion sequencer ports
`default_nettype none
module sacs_sequencer_assertions #(
  parameter int SETTLE_CYC = 1,
  parameter int TRIAL_CYC = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic single_ended_select_in,
  input wire logic [3:0] chan_in,
  input wire logic comp_positive_in,
  input wire logic vern_wr_in,
  input wire logic [7:0] vern_data_in,
  input wire logic [15:0] mux_en_out,
  input wire logic auto_zero_out,
  input wire logic sh_track_out,
  input wire logic preamp_to_comp_out,
  input wire logic [11:0] dac_code_out,
  input wire logic [11:0] result_out,
  input wire logic [7:0] vern_code_out,
  input wire logic busy_out,
  input wire logic done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // busy cycles counted up to the edge that sees the done pulse
  localparam int CONV = SETTLE_CYC + 12 * (TRIAL_CYC + 2);
  int busy_cnt_reg;
  // counts busy cycles of the running conversion
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) busy_cnt_reg <= 0;
    else busy_cnt_reg <= busy_out ? busy_cnt_reg + 1 : 0;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_hold_on; $rose(busy_out); endsequence
  sequence s_hold_off; $fell(busy_out); endsequence
  property p_sample_chan;
    !busy_out && $past(rst_n_in, 2) && $stable(chan_in)
      && $past(chan_in, 2) == chan_in
      |-> mux_en_out == 16'h0001 << chan_in && !auto_zero_out;
  endproperty
  property p_se_hold;
    busy_out && single_ended_select_in
      |-> mux_en_out == 16'h0000 && auto_zero_out;
  endproperty
  property p_pair_hold;
    busy_out && !single_ended_select_in
      |-> mux_en_out == 16'h0001 << (chan_in | 4'h1) && !auto_zero_out;
  endproperty
  property p_freeze;
    busy_out |-> !sh_track_out && preamp_to_comp_out;
  endproperty
  property p_preload;
    s_hold_on |-> ##[0:2] dac_code_out == 12'h800;
  endproperty
  property p_finish;
    s_hold_off |-> done_out && sh_track_out && !preamp_to_comp_out;
  endproperty
  property p_latency;
    done_out |-> busy_cnt_reg == CONV;
  endproperty
  property p_result_hold;
    !done_out |-> $stable(result_out);
  endproperty
  property p_vern;
    vern_wr_in |=> vern_code_out == $past(vern_data_in);
  endproperty
  a_sample_chan: assert property (p_sample_chan)
    else $error("mux not on addressed channel in sample");
  a_se_hold: assert property (p_se_hold)
    else $error("single-ended hold switches wrong");
  a_pair_hold: assert property (p_pair_hold)
    else $error("pair hold not on negative leg");
  a_freeze: assert property (p_freeze)
    else $error("feedback path not frozen while busy");
  a_preload: assert property (p_preload)
    else $error("no top-bit preload at start");
  a_finish: assert property (p_finish)
    else $error("bad return to sample");
  a_latency: assert property (p_latency)
    else $error("conversion length wrong");
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without completion");
  a_vern: assert property (p_vern)
    else $error("vernier code not loaded");
endmodule
bind sacs_sequencer sacs_sequencer_assertions #(
  .SETTLE_CYC(SETTLE_CYC), .TRIAL_CYC(TRIAL_CYC)
) u_sacs_sequencer_assertions (.ref_clk_in, .rst_n_in, .start_in,
  .single_ended_select_in, .chan_in, .comp_positive_in, .vern_wr_in,
  .vern_data_in, .mux_en_out, .auto_zero_out, .sh_track_out,
  .preamp_to_comp_out, .dac_code_out, .result_out, .vern_code_out,
  .busy_out, .done_out);
`default_nettype wire

// *** test/sacs_sequencer_tb.sv ***
// self-checking bench for the conversion sequencer
`default_nettype none
module sacs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import sacs_pkg::*;
  localparam int SETTLE = 1;
  localparam int TRIAL = 1;
  // edges from the start edge to the one that raises done
  localparam int LAT = SETTLE + 12 * (TRIAL + 2) + 1;
  logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, se = 1'b0;
  logic comp, vwr = 1'b0, az, sh, pre, busy, done;
  logic [3:0] ch = 4'h0;
  logic [7:0] vd = 8'h00, vc;
  logic [11:0] tgt = 12'h000, dac, res;
  logic [15:0] mux;
  int error_cnt = 0, comparisons = 0;
  always #4 clk = ~clk;
  sacs_sequencer #(.SETTLE_CYC(SETTLE), .TRIAL_CYC(TRIAL))
    u_sacs_sequencer (
    .ref_clk_in(clk), .rst_n_in(rst_n), .start_in(start),
    .single_ended_select_in(se), .chan_in(ch), .comp_positive_in(comp),
    .vern_wr_in(vwr), .vern_data_in(vd), .mux_en_out(mux),
    .auto_zero_out(az), .sh_track_out(sh), .preamp_to_comp_out(pre),
    .dac_code_out(dac), .result_out(res), .vern_code_out(vc),
    .busy_out(busy), .done_out(done));
  sacs_afe_model u_sacs_afe_model (.dac_in(dac), .level_in(tgt),
    .comp_positive_out(comp));
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // waits for the completion pulse, counting edges
  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    if (n >= 200) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic conv(input logic [11:0] v, input logic s,
                      input logic [3:0] c);
    int n;
    tgt = v;
    se = s;
    ch = c;
    start = 1'b1;
    tick();
    start = 1'b0;
    tick();
    chk("hold az", s, az);
    chk("hold sh", 16'h0000, sh);
    chk("hold pre", 16'h0001, pre);
    chk("hold mux", s ? 16'h0000 : 16'h0001 << (c | 4'h1), mux);
    wait_done(n);
    chk("cycles", LAT, n + 1);
    chk("result", v, res);
    chk("dac", v, dac);
    chk("mux", 16'h0001 << c, mux);
    chk("track", 16'h0001, sh);
    tick();
  endtask
  task automatic t_reset();
    chk("vern", 8'h80, vc);
    chk("result", 12'h000, res);
    chk("busy", 1'b0, busy);
  endtask
  task automatic t_codes();
    logic [11:0] tab [5] = '{12'hFFF, 12'h7FF, 12'h000, 12'hA5A, 12'h001};
    foreach (tab[i]) conv(tab[i], 1'b1, 4'h3);
  endtask
  task automatic t_pairs();
    logic [3:0] tab [3] = '{4'h0, 4'h6, 4'hF};
    foreach (tab[i]) conv(12'h5C3, 1'b0, tab[i]);
  endtask
  // start held high: refused mid-run, retaken after completion
  task automatic t_refuse();
    int n;
    tgt = 12'h321;
    start = 1'b1;
    tick();
    wait_done(n);
    chk("first", 12'h321, res);
    tgt = 12'hC0D;
    tick();
    wait_done(n);
    start = 1'b0;
    chk("gap", LAT, n);
    chk("second", 12'hC0D, res);
    tick();
  endtask
  task automatic t_vern();
    logic [7:0] tab [3] = '{8'h00, 8'hFF, 8'h5A};
    vwr = 1'b1;
    foreach (tab[i]) begin
      vd = tab[i];
      tick();
      chk("vern", tab[i], vc);
    end
    vwr = 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    tick();
    t_reset();
    t_codes();
    t_pairs();
    t_refuse();
    t_vern();
    tally_and_finish();
  end
endmodule
`default_nettype wire
